//--- design/vsc_regs.sv
// signalling configuration bank behind the serial control port
// Operation
// - second signalling register bit 7 enables widescreen output, reset 0.
// - first signalling register bits 7..4 give the enhanced services group.
// - first signalling register bits 3..0 give the aspect ratio group.
// - second register bits 2..0 give word bits 10..8, subtitles.
// - second register bits 5..3 give word bits 13..11, reserved group.
// - real-time register bit 7 makes the colour detection bit used while realtime_control_enable is high.
// - real-time register bit 6 picks register or input field sequence while realtime_control_enable is high.
// - six-bit burst start position, reset 33, NTSC value 25.
// - six-bit burst end position, reset 29 for both standards.
// - first payload byte goes out lsb first once cg_line_start starts the line.
// - third copy register bit 7 enables payload output, reset 0.
// - several data bytes in one write fill consecutive registers.
// - write frame is start, address, subaddress, data, acks, stop.
`timescale 1ns/1ns
module vsc_regs #(
   parameter int CG_BIT_CYCLES = 1
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               reset_n,
   // serial control pins
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   // real-time control input
   input  wire logic               rtc_color_bit,
   input  wire logic               rtc_field_bit,
   input  wire logic               realtime_control_enable,
   input  wire logic               field_sequence_bit,
   // line timing
   input  wire logic               line_start,
   input  wire logic               cg_line_start,
   // configuration and derived controls
   output vsc_pkg::vsc_cfg_type    cfg,
   output logic                    color_detect_used,
   output logic                    field_sequence_out,
   // copy generation serial data
   output logic                    cg_bit,
   output logic                    cg_active
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [vsc_pkg::REG_COUNT-1:0][7:0] regs;
      logic [7:0]                         ptr;
      vsc_pkg::vsc_cfg_type               cfg;
      logic                               col;
      logic                               fis;
   } vsc_regs_state_type;

   vsc_regs_state_type    r_q;
   vsc_regs_state_type    r_d;
   vsc_pkg::vsc_byte_type rx;

   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   function automatic logic in_map(input logic [7:0] a);
      in_map = (a >= vsc_pkg::ADR_WSS_LO) && (a <= vsc_pkg::ADR_CG_TAIL);
   endfunction

   function automatic logic [2:0] reg_idx(input logic [7:0] a);
      logic [7:0] d;
      d       = a - vsc_pkg::ADR_WSS_LO;
      reg_idx = d[2:0];
   endfunction

   function automatic vsc_pkg::vsc_cfg_type to_cfg(
      input logic [vsc_pkg::REG_COUNT-1:0][7:0] g);
      vsc_pkg::vsc_cfg_type c;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] rt;
      logic [7:0] tl;
      hi = g[reg_idx(vsc_pkg::ADR_WSS_HI)];
      lo = g[reg_idx(vsc_pkg::ADR_WSS_LO)];
      rt = g[reg_idx(vsc_pkg::ADR_RT_BS)];
      tl = g[reg_idx(vsc_pkg::ADR_CG_TAIL)];
      c = '0;
      c.widescreen_out_enable = hi[vsc_pkg::WSS_EN_BIT];
      c.wss_word[7:4]   = lo[7:4];
      c.wss_word[3:0]   = lo[3:0];
      c.wss_word[10:8]  = hi[2:0];
      c.wss_word[13:11] = hi[5:3];
      c.rt_color_detect_select   = rt[vsc_pkg::RT_COL_BIT];
      c.rt_field_sequence_select = rt[vsc_pkg::RT_FIS_BIT];
      c.burst_start_pos = rt[vsc_pkg::POS_MSB:0];
      c.burst_end_pos   =
         g[reg_idx(vsc_pkg::ADR_BE)][vsc_pkg::POS_MSB:0];
      c.copy_generation_enable = tl[vsc_pkg::CG_EN_BIT];
      c.copy_generation_payload = {tl[3:0],
         g[reg_idx(vsc_pkg::ADR_CG1)],
         g[reg_idx(vsc_pkg::ADR_CG0)]};
      to_cfg = c;
   endfunction

   // ------------------------------------------------------------
   // serial control port
   // ------------------------------------------------------------
   vsc_i2c_slave u_port (
      .mclk    (mclk),
      .reset_n (reset_n),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .sda_out (sda_out),
      .sda_oe  (sda_oe),
      .rx      (rx)
   );

   // ------------------------------------------------------------
   // register file and line-aligned update
   // ------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      if (rx.valid) begin
         if (rx.first) begin
            r_d.ptr = rx.data;
         end else begin
            // reserved bits are stored as written; host keeps them 0
            if (in_map(r_q.ptr)) begin
               r_d.regs[reg_idx(r_q.ptr)] = rx.data;
            end
            r_d.ptr = r_q.ptr + 8'h01;
         end
      end
      // encoder sees new values only from the next line on
      if (line_start) begin
         r_d.cfg = to_cfg(r_q.regs);
      end
      // selects act only while realtime_control_enable is high
      r_d.col = r_q.cfg.rt_color_detect_select
              & realtime_control_enable
              & rtc_color_bit;
      r_d.fis = (r_q.cfg.rt_field_sequence_select
                 && realtime_control_enable)
              ? rtc_field_bit : field_sequence_bit;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         r_q      <= '0;
         r_q.regs <= vsc_pkg::RST_REGS;
         r_q.cfg  <= to_cfg(vsc_pkg::RST_REGS);
      end else begin
         r_q <= r_d;
      end
   end

   assign cfg                = r_q.cfg;
   assign color_detect_used  = r_q.col;
   assign field_sequence_out = r_q.fis;

   // ------------------------------------------------------------
   // copy generation line
   // ------------------------------------------------------------
   vsc_cg_serial #(
      .BIT_CYCLES (CG_BIT_CYCLES)
   ) u_cg (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .start     (cg_line_start),
      .enable    (r_q.cfg.copy_generation_enable),
      .payload   (r_q.cfg.copy_generation_payload),
      .cg_bit    (cg_bit),
      .cg_active (cg_active)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_WSS_ENABLE: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.widescreen_out_enable
                     == $past(r_q.regs[1][vsc_pkg::WSS_EN_BIT]))
      else $error("widescreen enable not taken from its bit");

   AST_WSS_ENH: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.wss_word[7:4] == $past(r_q.regs[0][7:4]))
      else $error("enhanced services group wrong");

   AST_WSS_ASPECT: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.wss_word[3:0] == $past(r_q.regs[0][3:0]))
      else $error("aspect ratio group wrong");

   AST_WSS_SUBT: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.wss_word[10:8] == $past(r_q.regs[1][2:0]))
      else $error("subtitles group wrong");

   AST_WSS_RSVD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.wss_word[13:11] == $past(r_q.regs[1][5:3]))
      else $error("reserved group wrong");

   AST_COLOR_SEL: assert property (@(posedge mclk)
      disable iff (!reset_n)
      color_detect_used |-> $past(cfg.rt_color_detect_select)
                            && $past(rtc_color_bit))
      else $error("colour detection used while not selected");

   AST_FIELD_SEL: assert property (@(posedge mclk)
      disable iff (!reset_n)
      ##1 field_sequence_out == ($past(cfg.rt_field_sequence_select
          && realtime_control_enable)
          ? $past(rtc_field_bit) : $past(field_sequence_bit)))
      else $error("field sequence taken from wrong source");

   AST_BS_RESET: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(reset_n) |-> cfg.burst_start_pos == 6'h21
                         && !cfg.copy_generation_enable)
      else $error("burst start reset value wrong");

   AST_BE_RESET: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(reset_n) |-> cfg.burst_end_pos == 6'h1d
                         && !cfg.widescreen_out_enable)
      else $error("burst end reset value wrong");

   AST_AUTO_INC: assert property (@(posedge mclk)
      disable iff (!reset_n)
      rx.valid && !rx.first |=> r_q.ptr == $past(r_q.ptr) + 8'h01)
      else $error("subaddress did not advance after data byte");

   AST_LINE_HOLD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !line_start ##1 reset_n |-> $stable(cfg))
      else $error("configuration changed inside a line");

   // ------------------------------------------------------------
   // register write and decode checks
   // ------------------------------------------------------------
   AST_SUB_LOAD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      rx.valid && rx.first |=> r_q.ptr == $past(rx.data))
      else $error("subaddress byte not loaded into pointer");

   AST_REG_WRITE: assert property (@(posedge mclk)
      disable iff (!reset_n)
      rx.valid && !rx.first && in_map(r_q.ptr)
      |=> r_q.regs[$past(reg_idx(r_q.ptr))] == $past(rx.data))
      else $error("data byte not stored at the pointer");

   AST_REG_QUIET: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !rx.valid |=> $stable(r_q.regs) && $stable(r_q.ptr))
      else $error("register bank changed without a data byte");

   AST_REGS_RESET: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(reset_n) |-> r_q.regs == vsc_pkg::RST_REGS)
      else $error("register bank not at defaults after reset");

   AST_BS_FIELD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.burst_start_pos
                     == $past(r_q.regs[2][vsc_pkg::POS_MSB:0]))
      else $error("burst start not taken from its field");

   AST_BE_FIELD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.burst_end_pos
                     == $past(r_q.regs[3][vsc_pkg::POS_MSB:0]))
      else $error("burst end not taken from its field");

   AST_CG_EN_FIELD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.copy_generation_enable
                     == $past(r_q.regs[6][vsc_pkg::CG_EN_BIT]))
      else $error("copy generation enable not taken from its bit");

   AST_CG_PAYLOAD: assert property (@(posedge mclk)
      disable iff (!reset_n)
      line_start |=> cfg.copy_generation_payload
                     == $past({r_q.regs[6][3:0], r_q.regs[5],
                               r_q.regs[4]}))
      else $error("copy generation payload assembled wrongly");

   AST_COLOR_ON: assert property (@(posedge mclk)
      disable iff (!reset_n)
      cfg.rt_color_detect_select && realtime_control_enable
      && rtc_color_bit |=> color_detect_used)
      else $error("selected colour detection bit not used");

   AST_COLOR_NEEDS_EN: assert property (@(posedge mclk)
      disable iff (!reset_n)
      color_detect_used |-> $past(realtime_control_enable))
      else $error("colour detection used without real-time enable");

   AST_FIS_FROM_REG: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !cfg.rt_field_sequence_select
      |=> field_sequence_out == $past(field_sequence_bit))
      else $error("field sequence not taken from the register bit");

endmodule

//--- design/vsc_pkg.sv
// shared constants and types of the signalling configuration bank
package vsc_pkg;

   // ------------------------------------------------------------
   // serial control port
   // ------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR    = 7'h44;
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // ------------------------------------------------------------
   // register offsets (subaddresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_WSS_LO  = 8'h26;
   localparam logic [7:0] ADR_WSS_HI  = 8'h27;
   localparam logic [7:0] ADR_RT_BS   = 8'h28;
   localparam logic [7:0] ADR_BE      = 8'h29;
   localparam logic [7:0] ADR_CG0     = 8'h2a;
   localparam logic [7:0] ADR_CG1     = 8'h2b;
   localparam logic [7:0] ADR_CG_TAIL = 8'h2c;
   localparam int         REG_COUNT   = 7;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int WSS_EN_BIT = 7;
   localparam int RT_COL_BIT = 7;
   localparam int RT_FIS_BIT = 6;
   localparam int CG_EN_BIT  = 7;
   localparam int POS_MSB    = 5;
   localparam int CG_BITS    = 20;
   localparam int WSS_BITS   = 14;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_WSS_LO  = 8'h00;
   localparam logic [7:0] RST_WSS_HI  = 8'h00;
   localparam logic [7:0] RST_RT_BS   = 8'h21;
   localparam logic [7:0] RST_BE      = 8'h1d;
   localparam logic [7:0] RST_CG0     = 8'h00;
   localparam logic [7:0] RST_CG1     = 8'h00;
   localparam logic [7:0] RST_CG_TAIL = 8'h00;
   localparam logic [REG_COUNT-1:0][7:0] RST_REGS = {
      RST_CG_TAIL, RST_CG1, RST_CG0, RST_BE,
      RST_RT_BS, RST_WSS_HI, RST_WSS_LO};

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_DATA, ST_DACK
   } vsc_i2c_st_type;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } vsc_byte_type;

   typedef struct packed {
      logic                  widescreen_out_enable;
      logic [WSS_BITS-1:0]   wss_word;
      logic                  rt_color_detect_select;
      logic                  rt_field_sequence_select;
      logic [POS_MSB:0]      burst_start_pos;
      logic [POS_MSB:0]      burst_end_pos;
      logic                  copy_generation_enable;
      logic [CG_BITS-1:0]    copy_generation_payload;
   } vsc_cfg_type;

endpackage

//--- design/vsc_i2c_slave.sv
// serial control port slave: write frames into a byte stream
`timescale 1ns/1ns
module vsc_i2c_slave (
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            reset_n,
   // serial pins
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output logic                 sda_out,
   output logic                 sda_oe,
   // received bytes
   output vsc_pkg::vsc_byte_type rx
);

   typedef struct packed {
      vsc_pkg::vsc_i2c_st_type st;
      logic                    scl;
      logic                    sda;
      logic [7:0]              sh;
      logic [3:0]              cnt;
      logic                    first;
      vsc_pkg::vsc_byte_type   rx;
   } vsc_i2c_state_type;

   vsc_i2c_state_type r_q;
   vsc_i2c_state_type r_d;
   logic              rise;
   logic              fall;
   logic              start_c;
   logic              stop_c;

   always_comb begin
      r_d          = r_q;
      r_d.rx.valid = 1'b0;
      r_d.scl      = scl_in;
      r_d.sda      = sda_in;
      rise    = scl_in & ~r_q.scl;
      fall    = ~scl_in & r_q.scl;
      start_c = r_q.scl & scl_in & r_q.sda & ~sda_in;
      stop_c  = r_q.scl & scl_in & ~r_q.sda & sda_in;
      if (start_c) begin
         r_d.st    = vsc_pkg::ST_ADDR;
         r_d.cnt   = 4'h0;
         r_d.first = 1'b1;
      end else if (stop_c) begin
         r_d.st = vsc_pkg::ST_IDLE;
      end else begin
         case (r_q.st)
            vsc_pkg::ST_ADDR, vsc_pkg::ST_DATA: begin
               if (rise) begin
                  r_d.sh  = {r_q.sh[6:0], sda_in};
                  r_d.cnt = r_q.cnt + 4'h1;
               end else if (fall && r_q.cnt == vsc_pkg::BYTE_BITS) begin
                  if (r_q.st == vsc_pkg::ST_DATA) begin
                     r_d.st      = vsc_pkg::ST_DACK;
                     r_d.rx.valid = 1'b1;
                     r_d.rx.first = r_q.first;
                     r_d.rx.data  = r_q.sh;
                  // only write frames to this device are answered
                  end else if (r_q.sh[7:1] == vsc_pkg::DEV_ADDR
                               && !r_q.sh[0]) begin
                     r_d.st = vsc_pkg::ST_AACK;
                  end else begin
                     r_d.st = vsc_pkg::ST_IDLE;
                  end
               end
            end
            vsc_pkg::ST_AACK, vsc_pkg::ST_DACK: begin
               if (fall) begin
                  r_d.st  = vsc_pkg::ST_DATA;
                  r_d.cnt = 4'h0;
                  if (r_q.st == vsc_pkg::ST_DACK) begin
                     r_d.first = 1'b0;
                  end
               end
            end
            default: r_d.st = vsc_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         r_q     <= '0;
         r_q.scl <= 1'b1;
         r_q.sda <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // acknowledge drives the line low for one bit time
   assign sda_oe  = (r_q.st == vsc_pkg::ST_AACK)
                 || (r_q.st == vsc_pkg::ST_DACK);
   assign sda_out = 1'b0;
   assign rx      = r_q.rx;

   AST_ACK_AFTER_FALL: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(sda_oe) |-> $past(r_q.scl) && !$past(scl_in)
                        && $past(r_q.cnt) == vsc_pkg::BYTE_BITS)
      else $error("acknowledge not started on eighth falling edge");

endmodule

//--- design/vsc_cg_serial.sv
// copy generation payload serialiser, least significant bit first
`timescale 1ns/1ns
module vsc_cg_serial #(
   parameter int BIT_CYCLES = 1
) (
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        reset_n,
   // control
   input  wire logic                        start,
   input  wire logic                        enable,
   input  wire logic [vsc_pkg::CG_BITS-1:0] payload,
   // serial out
   output logic                             cg_bit,
   output logic                             cg_active
);

   typedef struct packed {
      logic [vsc_pkg::CG_BITS-1:0] sh;
      logic [4:0]                  cnt;
      logic [15:0]                 div;
      logic                        act;
   } vsc_cgs_state_type;

   vsc_cgs_state_type r_q;
   vsc_cgs_state_type r_d;

   always_comb begin
      r_d = r_q;
      // a payload run starts only while enabled
      if (start && enable && !r_q.act) begin
         r_d.sh  = payload;
         r_d.cnt = 5'(vsc_pkg::CG_BITS);
         r_d.div = 16'h0000;
         r_d.act = 1'b1;
      end else if (r_q.act) begin
         if (r_q.div == 16'(BIT_CYCLES - 1)) begin
            r_d.div = 16'h0000;
            r_d.sh  = r_q.sh >> 1;
            r_d.cnt = r_q.cnt - 5'h01;
            if (r_q.cnt == 5'h01) begin
               r_d.act = 1'b0;
            end
         end else begin
            r_d.div = r_q.div + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign cg_bit    = r_q.sh[0];
   assign cg_active = r_q.act;

   AST_CG_GATED: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(cg_active) |-> $past(enable) && $past(start))
      else $error("copy generation sent while disabled");

   AST_CG_LSB_FIRST: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(cg_active) |-> cg_bit == $past(payload[0]))
      else $error("copy generation did not start with its lsb");

endmodule

//--- verif/vsc_host_model.sv
// serial control port master model driving write frames
`timescale 1ns/1ns
module vsc_host_model (
   // clock
   input  wire logic mclk,
   // serial pins
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_line
);

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // data only moves while the clock is low
   task automatic put_bit(input logic b, output logic seen);
      sda_low <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(2);
      seen = sda_line;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask

   task automatic send(input logic [7:0] b, inout int acks);
      int   i;
      logic s;
      for (i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      if (s === 1'b0) begin
         acks++;
      end
   endtask

   // start, address, subaddress, data bytes, stop; counts acknowledges
   task automatic frame(input logic [7:0] adr, input logic [7:0] sub,
                        input logic [7:0][7:0] d, input int n,
                        output int acks);
      int i;
      acks = 0;
      tick(1);
      sda_low <= 1'b1;
      tick(3);
      scl <= 1'b0;
      tick(2);
      send(adr, acks);
      send(sub, acks);
      for (i = 0; i < n; i++) begin
         send(d[i], acks);
      end
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(3);
      sda_low <= 1'b0;
      tick(4);
   endtask

endmodule

//--- verif/vbi_signalling_config_tb.sv
// self-checking bench of the signalling configuration bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
   end \
end
module vbi_signalling_config_tb;

   localparam int CGC = 2;

   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic rtc_color_bit = 1'b0;
   logic rtc_field_bit = 1'b0;
   logic realtime_control_enable = 1'b0;
   logic field_sequence_bit = 1'b0;
   logic line_start = 1'b0;
   logic cg_line_start = 1'b0;
   logic scl, sda_low, sda_in, sda_out, sda_oe;
   logic cg_bit, cg_active, color_detect_used, field_sequence_out;
   vsc_pkg::vsc_cfg_type cfg, old;
   logic [6:0][7:0] img;
   logic [7:0][7:0] d;
   logic [31:0]     seed = 32'h017c_d80e;
   logic [31:0]     r;
   int              fails = 0;
   int              total_checks = 0;
   int              k, j, acks;

   // open-drain data line with pull-up
   assign sda_in = ~(sda_low | (sda_oe & ~sda_out));

   always #25 mclk = ~mclk;

   vsc_regs #(.CG_BIT_CYCLES(CGC)) vsc_regs_inst (
      .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .rtc_color_bit(rtc_color_bit),
      .rtc_field_bit(rtc_field_bit),
      .realtime_control_enable(realtime_control_enable),
      .field_sequence_bit(field_sequence_bit), .line_start(line_start),
      .cg_line_start(cg_line_start), .cfg(cfg),
      .color_detect_used(color_detect_used),
      .field_sequence_out(field_sequence_out), .cg_bit(cg_bit),
      .cg_active(cg_active));

   vsc_host_model vsc_host_model_inst (
      .mclk(mclk), .scl(scl), .sda_low(sda_low), .sda_line(sda_in));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic vsc_pkg::vsc_cfg_type exp_cfg(logic [6:0][7:0] g);
      vsc_pkg::vsc_cfg_type c;
      c.widescreen_out_enable = g[1][7];
      c.wss_word = {g[1][5:0], g[0]};
      c.rt_color_detect_select = g[2][7];
      c.rt_field_sequence_select = g[2][6];
      c.burst_start_pos = g[2][5:0];
      c.burst_end_pos = g[3][5:0];
      c.copy_generation_enable = g[6][7];
      c.copy_generation_payload = {g[6][3:0], g[5], g[4]};
      return c;
   endfunction

   task automatic chk_cfg();
      vsc_pkg::vsc_cfg_type e;
      e = exp_cfg(img);
      `CHK("wss_enable", e.widescreen_out_enable, cfg.widescreen_out_enable)
      `CHK("wss_word", e.wss_word, cfg.wss_word)
      `CHK("color_sel", e.rt_color_detect_select, cfg.rt_color_detect_select)
      `CHK("fis_sel", e.rt_field_sequence_select, cfg.rt_field_sequence_select)
      `CHK("burst_start", e.burst_start_pos, cfg.burst_start_pos)
      `CHK("burst_end", e.burst_end_pos, cfg.burst_end_pos)
      `CHK("cg_enable", e.copy_generation_enable, cfg.copy_generation_enable)
      `CHK("cg_payload", e, cfg)
   endtask

   task automatic line_pulse();
      @(posedge mclk) line_start <= 1'b1;
      @(posedge mclk) line_start <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // write n bytes from subaddress sub, then check the held configuration
   task automatic write_regs(input logic [7:0] sub, input int n);
      int i;
      int idx;
      old = exp_cfg(img);
      vsc_host_model_inst.frame(8'h88, sub, d, n, acks);
      `CHK("acks", n + 2, acks)
      `CHK("cfg_before_line", old, cfg)
      for (i = 0; i < n; i++) begin
         idx = int'(sub) - 'h26 + i;
         if (idx >= 0 && idx < 7) begin
            img[idx] = d[i];
         end
      end
      line_pulse();
      chk_cfg();
   endtask

   task automatic cg_run(input logic en);
      int b;
      logic [19:0] p;
      vsc_pkg::vsc_cfg_type e;
      e = exp_cfg(img);
      p = e.copy_generation_payload;
      @(posedge mclk) cg_line_start <= 1'b1;
      @(posedge mclk) cg_line_start <= 1'b0;
      #1;
      for (b = 0; b < 3 && cg_active !== 1'b1; b++) begin
         @(posedge mclk);
         #1;
      end
      for (b = 0; b < 20 && en; b++) begin
         `CHK("cg_active", 1'b1, cg_active)
         `CHK("cg_bit", p[b], cg_bit)
         repeat (CGC) @(posedge mclk);
         #1;
      end
      `CHK("cg_active_end", 1'b0, cg_active)
      `CHK("cg_bit_idle", 1'b0, cg_bit)
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge mclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      img = {8'h00, 8'h00, 8'h00, 8'h1d, 8'h21, 8'h00, 8'h00};
      d = '0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      #1;
      chk_cfg();
      // whole bank in one frame, random contents
      for (k = 0; k < 3; k++) begin
         for (j = 0; j < 7; j++) begin
            r = xs();
            d[j] = r[7:0];
         end
         d[1][6] = 1'b0;
         d[3][7:6] = 2'b00;
         d[6][6:4] = 3'b000;
         write_regs(vsc_pkg::ADR_WSS_LO, 7);
      end
      // single byte: the other standard's burst start
      d[0] = 8'h19;
      write_regs(vsc_pkg::ADR_RT_BS, 1);
      // pointer runs past the bank end
      d[0] = 8'h5a;
      d[1] = 8'h80;
      d[2] = 8'h3c;
      write_regs(vsc_pkg::ADR_CG1, 3);
      // foreign address and read direction get no acknowledge
      vsc_host_model_inst.frame(8'h8a, 8'h27, d, 1, acks);
      `CHK("acks_foreign", 0, acks)
      vsc_host_model_inst.frame(8'h89, 8'h27, d, 1, acks);
      `CHK("acks_read", 0, acks)
      line_pulse();
      chk_cfg();
      // real-time control selects, enable set first
      @(posedge mclk) realtime_control_enable <= 1'b1;
      for (k = 0; k < 4; k++) begin
         d[0] = {k[1:0], 6'h21};
         write_regs(vsc_pkg::ADR_RT_BS, 1);
         for (j = 0; j < 6; j++) begin
            r = xs();
            @(posedge mclk);
            rtc_color_bit <= r[0];
            rtc_field_bit <= r[1];
            field_sequence_bit <= r[2];
            repeat (2) @(posedge mclk);
            #1;
            `CHK("color_used", k[1] & r[0], color_detect_used)
            `CHK("fis_out", k[0] ? r[1] : r[2], field_sequence_out)
         end
      end
      // copy generation enabled, then disabled
      r = xs();
      d[0] = r[7:0];
      d[1] = r[15:8];
      d[2] = {1'b1, 3'b000, r[19:16]};
      write_regs(vsc_pkg::ADR_CG0, 3);
      cg_run(1'b1);
      d[0] = {4'h0, r[23:20]};
      write_regs(vsc_pkg::ADR_CG_TAIL, 1);
      cg_run(1'b0);
      // mid-run reset brings back every default, bank included
      @(posedge mclk) reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      img = {8'h00, 8'h00, 8'h00, 8'h1d, 8'h21, 8'h00, 8'h00};
      chk_cfg();
      line_pulse();
      chk_cfg();
      tally_and_finish();
   end

endmodule
